// [logic/ssc_pkg.sv]
// Package for the speed command block: constants and carrier types
package ssc_pkg;
	// Register byte offsets
	localparam logic [7:0] SSC_OFS_CTRL = 8'h00;
	localparam logic [7:0] SSC_OFS_SYS = 8'h04;
	localparam logic [7:0] SSC_OFS_GAIN = 8'h08;
	localparam logic [7:0] SSC_OFS_CLAMP = 8'h0C;
	localparam logic [7:0] SSC_OFS_OFFSET = 8'h10;
	localparam logic [7:0] SSC_OFS_POT = 8'h14;
	localparam logic [7:0] SSC_OFS_ANALOG = 8'h18;
	localparam logic [7:0] SSC_OFS_MEAS = 8'h1C;
	localparam logic [7:0] SSC_OFS_STATUS = 8'h20;
	localparam logic [7:0] SSC_OFS_REF = 8'h24;
	localparam logic [7:0] SSC_OFS_ZBAND = 8'h28;
	localparam logic [7:0] SSC_OFS_DATA = 8'h40;
	// System parameter field positions
	localparam int SSC_SYS_LOCK_BIT = 0;
	localparam int SSC_SYS_ANA_BIT = 1;
	localparam int SSC_SYS_DIR_BIT = 2;
	// Control field positions
	localparam int SSC_CTRL_AUTO_EN_BIT = 0;
	localparam int SSC_CTRL_APPLY_BIT = 1;
	// Reset values
	localparam logic [2:0] SSC_SYS_RESET = 3'h2;
	localparam logic [12:0] SSC_GAIN_RESET = 13'h0226;
	localparam logic [12:0] SSC_CLAMP_RESET = 13'h0000;
	localparam logic [15:0] SSC_OFFSET_RESET = 16'h0000;
	localparam logic [12:0] SSC_POT_RESET = 13'h0000;
	localparam logic [13:0] SSC_RAMP_RESET = 14'h0005;
	localparam logic [12:0] SSC_ZBAND_RESET = 13'h000A;
	// Speed limits in r/min, ramp limits in ms per 1000 r/min
	localparam logic [12:0] SSC_SPD_MIN = 13'h000A;
	localparam logic [12:0] SSC_SPD_MAX = 13'h157C;
	localparam logic [13:0] SSC_RAMP_MIN = 14'h0005;
	localparam logic [13:0] SSC_RAMP_MAX = 14'h2710;
	localparam logic [12:0] SSC_BRAKE_BAND = 13'h001E;
	// Timing: brake hold time and per-ms tick
	localparam int SSC_CLK_MHZ = 250;
	localparam int SSC_BRAKE_MS = 10;
	localparam int SSC_MS_CYCLES = SSC_CLK_MHZ * 1000;
	// Analog input scale: millivolts, signed
	localparam int SSC_MV_PER_V = 1000;
	// Discrete inputs from the host
	typedef struct packed {
		logic cw;
		logic ccw;
		logic servo_on;
		logic brake_release;
		logic [2:0] op_sel;
	} ssc_din_t;
	// Discrete outputs to the host and power stage
	typedef struct packed {
		logic ready;
		logic zero_speed;
		logic brake_ctl;
		logic excite;
		logic dir_cw;
	} ssc_dout_t;
endpackage

// [logic/ssc_speed_cmd.sv]
// Speed control mode command logic with AHB-Lite register slave
// Behaviour
// RL1 - Analog enabled, select 0: data zero, speed from internal pot
// RL2 - Internal pot speed is zero or 10 to 5500 r/min, default zero
// RL3 - Ramp is ms per 1000 r/min, shared, 5 to 10000
// RL4 - Analog enabled, select 1: data one from external voltage
// RL5 - External voltage scaled by gain 0 to 5500, default 550
// RL6 - Below clamp forced to zero, only in free mode
// RL7 - Offset voltage shifts zero point, gain unchanged
// RL8 - Auto offset apply takes present reading as offset
// RL9 - Analog enabled: stored speeds used for data two to seven
// RL10 - Analog disabled: stored speeds for all eight data
// RL11 - System parameter changes act only after power cycle
// RL12 - Free mode: de-excite when stopped, excite at start
// RL13 - Lock mode: excitation follows servo-on input
// RL14 - Brake released with excitation, held without it
// RL15 - Direction setting maps run inputs to rotation
// RL16 - Negative speed command reverses rotation
// RL17 - Run input on starts run at selected speed
// RL18 - Run off or both on decelerates to stop
// RL19 - Zero-speed output after run ends inside zero band
// RL20 - Free mode brake output off after 10 ms within 30 r/min
// RL21 - Ready when brake-release on, and servo-on in lock mode
// RL22 - Select bits form binary index, bit two most significant
// RL23 - Ready off while operating
// RL24 - Analog speed is (voltage minus offset) times gain, limited
// RL25 - Ramp changes reference linearly at set rate
`timescale 1ns/100ps
module ssc_speed_cmd (
	// Clock and reset
	input wire logic clk_sys_in,
	input wire logic rst_in,
	// AHB-Lite slave
	input wire logic hsel_in,
	input wire logic [31:0] haddr_in,
	input wire logic [1:0] htrans_in,
	input wire logic hwrite_in,
	input wire logic [2:0] hsize_in,
	input wire logic [31:0] hwdata_in,
	input wire logic hready_in,
	output logic [31:0] hrdata_out,
	output logic hreadyout_out,
	output logic hresp_out,
	// Discrete pins from the host
	input wire ssc_pkg::ssc_din_t din_in,
	// Discrete pins out
	output ssc_pkg::ssc_dout_t dout_out,
	// Speed reference to the drive loop, signed r/min
	output logic signed [13:0] speed_ref_out
);
	import ssc_pkg::*;

	// Magnitude of a signed value, clamped to the top speed
	function automatic logic [12:0] sat_spd(input logic signed [31:0] v);
		logic signed [31:0] a;
		a = (v < 0) ? -v : v;
		if (a > 32'(SSC_SPD_MAX)) begin
			sat_spd = SSC_SPD_MAX;
		end else begin
			sat_spd = a[12:0];
		end
	endfunction

	// Absolute value of a signed speed
	function automatic logic [12:0] abs_spd(input logic signed [13:0] v);
		logic signed [13:0] a;
		a = (v < 0) ? -v : v;
		abs_spd = a[12:0];
	endfunction

	typedef enum logic [1:0] {
		SSC_IDLE = 2'b00,
		SSC_RUN = 2'b01,
		SSC_STOP = 2'b10
	} ssc_state_t;

	// Registers
	// Stored like a nonvolatile parameter: keeps its value through rst_in
	logic [2:0] sys_pend_reg = SSC_SYS_RESET;
	logic [2:0] sys_live_reg;
	logic sys_loaded_reg;
	logic auto_en_reg;
	logic [12:0] gain_reg;
	logic [12:0] clamp_reg;
	logic signed [15:0] offset_reg;
	logic [12:0] pot_reg;
	logic [13:0] ramp_reg;
	logic signed [15:0] analog_reg;
	logic signed [13:0] meas_reg;
	logic [12:0] zband_reg;
	logic signed [13:0] data_mem [8];
	logic [13:0] data_ramp_mem [8];
	logic [6:0] sync1_reg;
	logic [6:0] sync2_reg;
	ssc_state_t state_reg;
	logic signed [13:0] ref_reg;
	logic [21:0] ms_cnt_reg;
	logic [13:0] step_cnt_reg;
	logic [17:0] brake_cnt_reg;
	logic [4:0] brake_ms_reg;
	logic wr_pend_reg;
	logic [7:0] addr_reg;

	// Pin synchronisers; first stage read only by second
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			sync1_reg <= 7'h00;
			sync2_reg <= 7'h00;
		end else begin
			sync1_reg <= din_in;
			sync2_reg <= sync1_reg;
		end
	end

	logic cw_s, ccw_s, son_s, brel_s;
	logic [2:0] sel_s;
	assign {cw_s, ccw_s, son_s, brel_s, sel_s} = sync2_reg;
	logic lock_mode, ana_en, dir_cw_set;
	assign lock_mode = sys_live_reg[SSC_SYS_LOCK_BIT];
	assign ana_en = sys_live_reg[SSC_SYS_ANA_BIT];
	assign dir_cw_set = sys_live_reg[SSC_SYS_DIR_BIT];

	// AHB-Lite address phase capture; zero wait states
	logic ahb_go;
	assign ahb_go = hsel_in && hready_in && htrans_in[1];
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			wr_pend_reg <= 1'b0;
			addr_reg <= 8'h00;
		end else begin
			wr_pend_reg <= ahb_go && hwrite_in;
			if (ahb_go) begin
				addr_reg <= haddr_in[7:0];
			end
		end
	end

	// Read data: registered in the address phase
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			hrdata_out <= 32'h0000_0000;
		end else if (ahb_go && !hwrite_in) begin
			hrdata_out <= 32'h0000_0000;
			if (haddr_in[7:5] == SSC_OFS_DATA[7:5]) begin
				hrdata_out <= {2'b00, data_ramp_mem[haddr_in[4:2]],
					2'b00, data_mem[haddr_in[4:2]]};
			end else begin
				unique case (haddr_in[7:0])
				SSC_OFS_CTRL: hrdata_out <= {31'h0, auto_en_reg};
				SSC_OFS_SYS: hrdata_out <= {21'h0, sys_live_reg,
					5'h00, sys_pend_reg};
				SSC_OFS_GAIN: hrdata_out <= {19'h0, gain_reg};
				SSC_OFS_CLAMP: hrdata_out <= {19'h0, clamp_reg};
				SSC_OFS_OFFSET: hrdata_out <= {{16{offset_reg[15]}},
					offset_reg};
				SSC_OFS_POT: hrdata_out <= {2'b00, ramp_reg,
					3'h0, pot_reg};
				SSC_OFS_ZBAND: hrdata_out <= {19'h0, zband_reg};
				SSC_OFS_STATUS: hrdata_out <= {27'h0, dout_out};
				SSC_OFS_REF: hrdata_out <= {{18{ref_reg[13]}}, ref_reg};
				default: hrdata_out <= 32'h0000_0000;
				endcase
			end
		end
	end

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			hreadyout_out <= 1'b1;
			hresp_out <= 1'b0;
		end else begin
			hreadyout_out <= 1'b1;
			hresp_out <= 1'b0;
		end
	end

	// Register writes in the data phase
	logic wr_ctrl, wr_sys, wr_pot;
	assign wr_ctrl = wr_pend_reg && addr_reg == SSC_OFS_CTRL;
	assign wr_sys = wr_pend_reg && addr_reg == SSC_OFS_SYS;
	assign wr_pot = wr_pend_reg && addr_reg == SSC_OFS_POT;
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			auto_en_reg <= 1'b0;
			gain_reg <= SSC_GAIN_RESET;
			clamp_reg <= SSC_CLAMP_RESET;
			offset_reg <= SSC_OFFSET_RESET;
			pot_reg <= SSC_POT_RESET;
			ramp_reg <= SSC_RAMP_RESET;
			analog_reg <= 16'h0000;
			meas_reg <= 14'h0000;
			zband_reg <= SSC_ZBAND_RESET;
		end else if (wr_pend_reg) begin
			if (wr_ctrl) begin
				auto_en_reg <= hwdata_in[SSC_CTRL_AUTO_EN_BIT];
				if (hwdata_in[SSC_CTRL_APPLY_BIT] && auto_en_reg) begin
					offset_reg <= analog_reg; // RL8
				end
			end
			if (addr_reg == SSC_OFS_GAIN) begin
				gain_reg <= sat_spd(32'(hwdata_in[15:0])); // RL5
			end
			if (addr_reg == SSC_OFS_CLAMP) begin
				clamp_reg <= sat_spd(32'(hwdata_in[15:0]));
			end
			if (addr_reg == SSC_OFS_OFFSET && !auto_en_reg) begin
				offset_reg <= hwdata_in[15:0];
			end
			if (wr_pot) begin
				// RL2
				if (hwdata_in[12:0] < SSC_SPD_MIN) begin
					pot_reg <= 13'h0000;
				end else begin
					pot_reg <= sat_spd(32'(hwdata_in[12:0]));
				end
				// RL3
				if (hwdata_in[29:16] < SSC_RAMP_MIN) begin
					ramp_reg <= SSC_RAMP_MIN;
				end else if (hwdata_in[29:16] > SSC_RAMP_MAX) begin
					ramp_reg <= SSC_RAMP_MAX;
				end else begin
					ramp_reg <= hwdata_in[29:16];
				end
			end
			if (addr_reg == SSC_OFS_ANALOG) begin
				analog_reg <= hwdata_in[15:0];
			end
			if (addr_reg == SSC_OFS_MEAS) begin
				meas_reg <= hwdata_in[13:0];
			end
			if (addr_reg == SSC_OFS_ZBAND) begin
				zband_reg <= hwdata_in[12:0];
			end
		end
	end

	// Pending system word; no reset so a write survives the next power cycle
	always_ff @(posedge clk_sys_in) begin
		if (wr_sys) begin
			sys_pend_reg <= hwdata_in[2:0]; // RL11
		end
	end

	// Operation data table
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			for (int i = 0; i < 8; i++) begin
				data_mem[i] <= 14'h0000;
				data_ramp_mem[i] <= SSC_RAMP_RESET;
			end
		end else if (wr_pend_reg && addr_reg[7:5] == SSC_OFS_DATA[7:5]) begin
			data_mem[addr_reg[4:2]] <= hwdata_in[13:0];
			data_ramp_mem[addr_reg[4:2]] <= hwdata_in[29:16];
		end
	end

	// System parameters latch once after reset (power-up only)
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			sys_live_reg <= SSC_SYS_RESET;
			sys_loaded_reg <= 1'b0;
		end else if (!sys_loaded_reg) begin
			sys_live_reg <= sys_pend_reg; // RL11
			sys_loaded_reg <= 1'b1;
		end
	end

	// Speed command source selection
	logic [2:0] op_num;
	logic signed [31:0] ana_prod;
	logic signed [13:0] target;
	logic [13:0] ramp_sel;
	logic [12:0] ana_mag;
	assign op_num = sel_s; // RL22
	always_comb begin
		ana_prod = (32'(analog_reg) - 32'(offset_reg)) // RL7
			* $signed(32'(gain_reg)) / SSC_MV_PER_V; // RL24
		ana_mag = sat_spd(ana_prod);
		if (!lock_mode && ana_mag < clamp_reg) begin
			ana_mag = 13'h0000; // RL6
		end
		target = data_mem[op_num]; // RL9 RL10
		ramp_sel = data_ramp_mem[op_num];
		if (ana_en && op_num == 3'd0) begin
			target = {1'b0, pot_reg}; // RL1
			ramp_sel = ramp_reg;
		end else if (ana_en && op_num == 3'd1) begin
			target = ana_prod < 0 ? -{1'b0, ana_mag} : {1'b0, ana_mag}; // RL4
			ramp_sel = ramp_reg;
		end
	end

	// Run state: single run input starts, release or both stop
	logic run_req;
	assign run_req = (cw_s ^ ccw_s) && brel_s && (!lock_mode || son_s);
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			state_reg <= SSC_IDLE;
		end else begin
			unique case (state_reg)
			SSC_IDLE: if (run_req) state_reg <= SSC_RUN; // RL17
			SSC_RUN: if (!run_req) state_reg <= SSC_STOP; // RL18
			SSC_STOP: begin
				if (run_req) begin
					state_reg <= SSC_RUN;
				end else if (ref_reg == 14'sd0) begin
					state_reg <= SSC_IDLE;
				end
			end
			default: state_reg <= SSC_IDLE;
			endcase
		end
	end

	// Linear ramp: one r/min step every ramp ms/1000 r/min microseconds
	// Longest ramp needs 2.5 million cycles per step, hence 22 bits
	logic [21:0] step_cycles;
	logic signed [13:0] goal;
	assign step_cycles = 22'(ramp_sel) * 22'(SSC_CLK_MHZ);
	assign goal = (state_reg == SSC_RUN) ? target : 14'sd0;
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			ref_reg <= 14'sd0;
			ms_cnt_reg <= 22'h00_0000;
		end else if (ref_reg == goal) begin
			ms_cnt_reg <= 22'h00_0000;
		end else if (ms_cnt_reg + 22'd1 >= step_cycles) begin
			ms_cnt_reg <= 22'h00_0000;
			ref_reg <= (ref_reg < goal) ? ref_reg + 14'sd1
				: ref_reg - 14'sd1; // RL25 RL3
		end else begin
			ms_cnt_reg <= ms_cnt_reg + 22'd1;
		end
	end

	// Brake settle timer: speed within 30 r/min for 10 ms
	logic in_band;
	assign in_band = abs_spd(meas_reg) <= SSC_BRAKE_BAND;
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			brake_cnt_reg <= 18'h0_0000;
			// Starts settled so a motor stopped at reset stays free
			brake_ms_reg <= 5'(SSC_BRAKE_MS);
		end else if (!in_band || state_reg == SSC_RUN) begin
			brake_cnt_reg <= 18'h0_0000;
			brake_ms_reg <= 5'h00;
		end else if (brake_ms_reg < 5'(SSC_BRAKE_MS)) begin
			if (brake_cnt_reg == 18'(SSC_MS_CYCLES - 1)) begin
				brake_cnt_reg <= 18'h0_0000;
				brake_ms_reg <= brake_ms_reg + 5'd1; // RL20
			end else begin
				brake_cnt_reg <= brake_cnt_reg + 18'd1;
			end
		end
	end

	// Outputs, all registered
	logic excite_next, moving, rot_cw;
	always_comb begin
		moving = state_reg != SSC_IDLE;
		if (lock_mode) begin
			excite_next = son_s; // RL13
		end else begin
			excite_next = moving || brake_ms_reg < 5'(SSC_BRAKE_MS); // RL12
		end
		rot_cw = (cw_s == dir_cw_set); // RL15
		if (ref_reg < 0) begin
			rot_cw = !rot_cw; // RL16
		end
	end
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			dout_out <= 5'h00;
			speed_ref_out <= 14'sd0;
		end else begin
			dout_out.excite <= excite_next;
			dout_out.brake_ctl <= excite_next; // RL14 RL20
			dout_out.ready <= !moving && !cw_s && !ccw_s && brel_s
				&& (!lock_mode || son_s); // RL21 RL23
			dout_out.zero_speed <= !moving
				&& abs_spd(meas_reg) <= zband_reg; // RL19
			dout_out.dir_cw <= rot_cw;
			speed_ref_out <= ref_reg;
		end
	end
endmodule // ssc_speed_cmd

// [tb/ssc_speed_cmd_monitor.sv]
// Checker for the speed command block ports
`timescale 1ns/100ps
module ssc_speed_cmd_monitor (
	// Clock and reset
	input wire logic clk_sys_in,
	input wire logic rst_in,
	// Observed ports
	input wire logic hreadyout_out,
	input wire logic hresp_out,
	input wire ssc_pkg::ssc_din_t din_in,
	input wire ssc_pkg::ssc_dout_t dout_out,
	input wire logic signed [13:0] speed_ref_out
);
	import ssc_pkg::*;
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (rst_in);
	// Slave never stalls or errors
	chk_bus_okay: assert property (hreadyout_out && !hresp_out)
		else $error("bus answer not ready or not okay");
	chk_brake_excite: assert property (dout_out.brake_ctl == dout_out.excite)
		else $error("brake output differs from excitation");
	chk_ready_run: assert property (din_in.cw [*4] |-> !dout_out.ready)
		else $error("ready while running");
	chk_ready_brake: assert property
		((!din_in.brake_release) [*4] |-> !dout_out.ready)
		else $error("ready without brake release");
	// Reference moves by one step at most, then holds for at least 8 cycles
	chk_ref_spacing: assert property
		($changed(speed_ref_out) |=> $stable(speed_ref_out) [*8])
		else $error("reference steps too fast");
	chk_ref_unit: assert property
		(int'(speed_ref_out) - int'($past(speed_ref_out)) inside {-1, 0, 1})
		else $error("reference jumped");
	chk_ref_limit: assert property
		(speed_ref_out <= 5500 && speed_ref_out >= -5500)
		else $error("reference beyond top speed");
	chk_both_stop: assert property ((din_in.cw && din_in.ccw) [*6] |=>
		(($past(speed_ref_out) >= 0) ? speed_ref_out <= $past(speed_ref_out)
		: speed_ref_out >= $past(speed_ref_out)))
		else $error("speed grows with both run inputs on");
	// Main scenarios
	cover property (dout_out.excite && speed_ref_out != 0);
	cover property (din_in.cw && din_in.ccw);
	cover property (dout_out.ready);
endmodule // ssc_speed_cmd_monitor
bind ssc_speed_cmd ssc_speed_cmd_monitor u_ssc_speed_cmd_monitor (
	.clk_sys_in(clk_sys_in), .rst_in(rst_in), .hreadyout_out(hreadyout_out),
	.hresp_out(hresp_out), .din_in(din_in), .dout_out(dout_out),
	.speed_ref_out(speed_ref_out));

// [tb/ssc_host_model.sv]
// Host controller model driving the discrete pins
`timescale 1ns/100ps
module ssc_host_model (
	// Clock and reset
	input wire logic clk_sys_in,
	input wire logic rst_in,
	// Host program: run code 0 stop, 1 cw, 2 ccw, 3 both
	input wire logic [1:0] run_code_in,
	input wire logic [2:0] sel_in,
	input wire logic servo_in,
	input wire logic brake_in,
	input wire logic [3:0] dly_in,
	input wire logic ready_in,
	// Pins to the device
	output ssc_pkg::ssc_din_t din_out
);
	import ssc_pkg::*;
	logic [3:0] wait_reg;
	// Starts only once ready is seen, after a chosen delay
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			din_out <= '0;
			wait_reg <= '0;
		end else begin
			din_out.op_sel <= sel_in;
			din_out.servo_on <= servo_in;
			din_out.brake_release <= brake_in;
			if (run_code_in == 2'd0 || run_code_in == 2'd3) begin
				din_out.cw <= run_code_in[0];
				din_out.ccw <= run_code_in[0];
				wait_reg <= '0;
			end else if (ready_in || din_out.cw || din_out.ccw) begin
				if (wait_reg >= dly_in) begin
					din_out.cw <= (run_code_in == 2'd1);
					din_out.ccw <= (run_code_in == 2'd2);
				end else
					wait_reg <= wait_reg + 4'h1;
			end
		end
	end
endmodule // ssc_host_model

// [tb/ssc_speed_cmd_tb_top.sv]
// Bench for the speed command block: bus master, model and scenarios
`timescale 1ns/100ps
module ssc_speed_cmd_tb_top;
	import ssc_pkg::*;
	logic clk_sys_in = 0;
	logic rst_in = 1;
	logic hsel = 0;
	logic [31:0] haddr = '0;
	logic [1:0] htrans = '0;
	logic hwrite = 0;
	logic [31:0] hwdata = '0;
	logic [31:0] hrdata;
	logic hrdy;
	logic hresp;
	ssc_din_t din;
	ssc_dout_t dout;
	logic signed [13:0] sref;
	logic [1:0] run_code = '0;
	logic [2:0] sel = '0;
	logic servo = 0;
	logic brk = 0;
	logic [3:0] dly = '0;
	int bad_count = 0;
	int n_tests = 0;
	int seed = 32'h7b0c;
	int cur = 0;
	int mv;
	logic [31:0] rd;
	ssc_speed_cmd u_ssc_speed_cmd (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
		.hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
		.hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
		.hready_in(hrdy), .hrdata_out(hrdata), .hreadyout_out(hrdy),
		.hresp_out(hresp), .din_in(din), .dout_out(dout),
		.speed_ref_out(sref));
	ssc_host_model u_ssc_host_model (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
		.run_code_in(run_code), .sel_in(sel), .servo_in(servo),
		.brake_in(brk), .dly_in(dly), .ready_in(dout.ready), .din_out(din));
	// Clock of 4 ns
	initial begin
		forever #2 clk_sys_in = ~clk_sys_in;
	end
	// One single word transfer, entered just after a rising edge
	task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1;
		htrans <= 2'b10;
		haddr <= {24'h00_0000, a};
		hwrite <= w;
		do @(posedge clk_sys_in); while (hrdy !== 1'b1);
		hsel <= 0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge clk_sys_in); while (hrdy !== 1'b1);
		rd = hrdata;
	endtask
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			bad_count++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask
	task rchk(input string n, input logic [7:0] a, input logic [31:0] e);
		ahb(0, a, '0);
		chk(n, e, rd);
	endtask
	// Waits one ramp step per r/min of change, then compares
	task settle(input int t);
		repeat (((t > cur) ? t - cur : cur - t) * 1250 + 60)
			@(posedge clk_sys_in);
		chk("speed_ref", t, sref);
		cur = t;
	endtask
	// Model of the analog speed path
	function int ana(input int v, input int off, input int g, input int cl);
		int s;
		s = (v - off) * g / 1000;
		s = (s > 5500) ? 5500 : ((s < -5500) ? -5500 : s);
		return (s < cl && s > -cl) ? 0 : s;
	endfunction
	task give_verdict;
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// Watchdog
	initial begin
		repeat (90000) @(posedge clk_sys_in);
		bad_count++;
		give_verdict();
	end
	// Scenarios
	initial begin
		repeat (20) @(posedge clk_sys_in);
		rst_in <= 0;
		@(posedge clk_sys_in);
		rchk("gain", SSC_OFS_GAIN, 32'h0000_0226);
		rchk("sys", SSC_OFS_SYS, 32'h0000_0202);
		rchk("unmapped", 8'h30, 32'h0000_0000);
		chk("ready", 0, dout.ready);
		brk <= 1;
		repeat (6) @(posedge clk_sys_in);
		chk("ready", 1, dout.ready);
		chk("excite", 0, dout.excite);
		$display("test reset done");
		sel <= 3'h1;
		ahb(1, SSC_OFS_GAIN, 32'h0000_000A);
		mv = 400 + ($random(seed) & 255);
		ahb(1, SSC_OFS_ANALOG, mv);
		run_code <= 2'd1;
		repeat (20) @(posedge clk_sys_in);
		chk("excite", 1, dout.excite);
		chk("brake", 1, dout.brake_ctl);
		chk("dir", 0, dout.dir_cw);
		chk("ready", 0, dout.ready);
		chk("zero_speed", 0, dout.zero_speed);
		settle(ana(mv, 0, 10, 0));
		ahb(1, SSC_OFS_OFFSET, mv - 200);
		settle(ana(mv, mv - 200, 10, 0));
		ahb(1, SSC_OFS_CTRL, 32'h0000_0001);
		ahb(1, SSC_OFS_CTRL, 32'h0000_0003);
		settle(ana(mv, mv, 10, 0));
		ahb(1, SSC_OFS_CTRL, 32'h0000_0000);
		ahb(1, SSC_OFS_OFFSET, 32'h0000_0000);
		ahb(1, SSC_OFS_CLAMP, 32'h0000_000A);
		repeat (2000) @(posedge clk_sys_in);
		settle(ana(mv, 0, 10, 10));
		$display("test analog done");
		ahb(1, SSC_OFS_DATA + 8'h14, 32'h0005_3FFD);
		sel <= 3'h5;
		run_code <= 2'd2;
		repeat (20) @(posedge clk_sys_in);
		settle(-3);
		// Reversal follows the sign of the ramped reference
		chk("dir", 0, dout.dir_cw);
		run_code <= 2'd3;
		settle(0);
		$display("test digital done");
		ahb(1, SSC_OFS_SYS, 32'h0000_0005);
		rchk("sys", SSC_OFS_SYS, 32'h0000_0205);
		run_code <= 2'd0;
		rst_in <= 1;
		repeat (20) @(posedge clk_sys_in);
		rst_in <= 0;
		@(posedge clk_sys_in);
		rchk("sys", SSC_OFS_SYS, 32'h0000_0505);
		repeat (6) @(posedge clk_sys_in);
		chk("excite", 0, dout.excite);
		chk("ready", 0, dout.ready);
		servo <= 1;
		repeat (6) @(posedge clk_sys_in);
		chk("excite", 1, dout.excite);
		chk("brake", 1, dout.brake_ctl);
		chk("ready", 1, dout.ready);
		ahb(1, SSC_OFS_DATA, 32'h0005_0002);
		sel <= 3'h0;
		dly <= 4'h3;
		run_code <= 2'd1;
		repeat (30) @(posedge clk_sys_in);
		chk("dir", 1, dout.dir_cw);
		settle(2);
		run_code <= 2'd0;
		settle(0);
		chk("zero_speed", 1, dout.zero_speed);
		ahb(1, SSC_OFS_MEAS, 32'h0000_0064);
		repeat (2) @(posedge clk_sys_in);
		chk("zero_speed", 0, dout.zero_speed);
		$display("test lock done");
		give_verdict();
	end
endmodule // ssc_speed_cmd_tb_top
